// ### shared/gpio_irq_defines.svh
`ifndef GPIO_IRQ_DEFINES_SVH
`define GPIO_IRQ_DEFINES_SVH

// Register byte addresses as seen on the register port
`define OFF_STAT_LOW 32'h0b00_0108
`define OFF_STAT_HIGH 32'h0b00_010a
`define OFF_EN_LOW 32'h0b00_010c
`define OFF_EN_HIGH 32'h0b00_010e
`define OFF_TYPE_LOW 32'h0b00_0110
`define OFF_TYPE_HIGH 32'h0b00_0112
`define OFF_LVL_LOW 32'h0b00_0114
`define OFF_LVL_HIGH 32'h0b00_0116
`define OFF_MASK_LOW 32'h0b00_0120
`define OFF_MASK_HIGH 32'h0b00_0122

// Field positions inside the 32-pin vectors
`define LOW_MSB 15
`define LOW_LSB 0
`define HIGH_MSB 31
`define HIGH_LSB 16
`define CARRIER_PIN 15

// Reset values
`define RST_CFG 16'h0000
`define RST_STAT 16'h0000
`define RST_MASK 16'hffff
`define RST_RDATA 16'h0000

// Input synchroniser depth in flip-flops
`define SYNC_STAGES 2

`endif

// ### shared/gpio_irq_pkg.sv
package gpio_irq_pkg;

    // One 16-bit register half
    typedef logic [15:0] half_word_t;

    // Per-pin detection method, bit value 1 means edge
    typedef enum logic {
        trig_level,
        trig_edge
    } trig_kind_t;

    // Level sense, bit value 1 means high active
    typedef enum logic {
        pol_low,
        pol_high
    } polarity_t;

endpackage : gpio_irq_pkg

// ### verif/pin_source.sv
`timescale 1ns/1ps

module pin_source (
    input wire logic clk_in, // System clock
    input wire logic [31:0] level_in, // Levels the bench asks for
    output logic [31:0] pins_out, // General pin lines
    output logic carrier_out // Carrier-detect line
);
    // Quiet lines before the first edge
    initial begin
        pins_out = 32'h0000_8000;
        carrier_out = 1'b0;
    end

    // Levels move just after an edge, like a slow outside source
    always @(posedge clk_in) begin
        // Dead pin 15 line shows the opposite, so using it is caught
        pins_out <= {level_in[31:16], ~level_in[15], level_in[14:0]};
        carrier_out <= level_in[15];
    end
endmodule : pin_source

// ### verif/testbench.sv
`timescale 1ns/1ps
`include "gpio_irq_defines.svh"

module testbench;
    import gpio_irq_pkg::*;
    logic clk_in = 1'b0; // System clock
    logic srst_in = 1'b1; // Reset, high
    logic [31:0] addr_in = 32'h0; // Register address
    logic [15:0] wdata_in = 16'h0; // Write data
    logic wr_in = 1'b0; // Write strobe
    logic rd_in = 1'b0; // Read strobe
    logic [31:0] level = 32'h0; // Wanted pin levels
    logic [31:0] pins; // Pin lines
    logic carrier; // Carrier line
    logic [15:0] rdata_out; // Read data
    logic irq_out; // Interrupt request
    int miscompares = 0; // Failed compares
    int n_checks = 0; // All compares
    logic [15:0] rv; // Last 16-bit read
    logic [31:0] rv32; // Last paired read
    logic [31:0] old, r, e, p, s; // Random draws and expectations

    // Free-running clock
    always #20 clk_in = ~clk_in;

    pin_source src (
        .clk_in(clk_in),
        .level_in(level),
        .pins_out(pins),
        .carrier_out(carrier)
    );

    gpio_pin_interrupt_detect #(.PIN_COUNT(32)) dut (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .pins_in(pins),
        .carrier_detect_in(carrier),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .irq_out(irq_out)
    );

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic final_report();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // Wait whole cycles
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    // One write cycle; strobe drops one edge later
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    // One read cycle; data only in the next cycle
    task automatic rd(input logic [31:0] a);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 rv = rdata_out;
    endtask : rd

    // Low half then high half two bytes up
    task automatic wr32(input logic [31:0] a, input logic [31:0] d);
        wr(a, d[15:0]);
        wr(a + 32'h2, d[31:16]);
    endtask : wr32

    // Pair two halves into one pin vector
    task automatic rd32(input logic [31:0] a);
        rd(a + 32'h2);
        rv32[31:16] = rv;
        rd(a);
        rv32[15:0] = rv;
    endtask : rd32

    // Any change of an allowed pin
    function automatic logic [31:0] edge_exp(input logic [31:0] a, b, en);
        return (a ^ b) & en;
    endfunction : edge_exp

    // Allowed pins sitting at their active level
    function automatic logic [31:0] lvl_exp(input logic [31:0] v, pol, en);
        return ~(v ^ pol) & en;
    endfunction : lvl_exp

    // Hang guard, far above the expected run
    initial begin
        #400000;
        miscompares++;
        final_report();
    end

    // Main sequence
    initial begin
        r = $urandom(32'he233b275);
        tick(8);
        srst_in <= 1'b0;
        tick(2);
        rd32(`OFF_STAT_LOW);
        check(rv32, 32'h0);
        rd32(`OFF_EN_LOW);
        check(rv32, 32'h0);
        rd32(`OFF_TYPE_LOW);
        check(rv32, 32'h0);
        check({31'h0, irq_out}, 32'h0);
        // Unmapped place takes nothing and reads zero
        wr(32'h0b00_0100, 16'hffff);
        rd(32'h0b00_0100);
        check({16'h0, rv}, 32'h0);
        r = $urandom;
        wr(`OFF_TYPE_LOW, r[15:0]);
        rd(`OFF_TYPE_LOW);
        check({16'h0, rv}, {16'h0, r[15:0]});
        wr32(`OFF_TYPE_LOW, 32'hffffffff);
        for (int i = 0; i < 20; i++) begin
            old = level;
            r = (i == 0) ? ~old : $urandom;
            e = (i == 1) ? 32'h0 : ((i == 0) ? 32'hffffffff : $urandom);
            p = $urandom;
            wr32(`OFF_EN_LOW, e);
            // polarity scrambled while in edge mode
            wr32(`OFF_LVL_LOW, p);
            wr32(`OFF_STAT_LOW, 32'hffffffff);
            rd32(`OFF_EN_LOW);
            check(rv32, e);
            @(posedge clk_in);
            level <= r;
            tick(6);
            s = edge_exp(old, r, e);
            rd32(`OFF_STAT_LOW);
            check(rv32, s);
            check({31'h0, irq_out}, {31'h0, |s});
            // Partial clear: ones clear, zeros keep
            r = $urandom;
            wr32(`OFF_STAT_LOW, r);
            rd32(`OFF_STAT_LOW);
            check(rv32, s & ~r);
        end
        // level mode with random active levels
        wr32(`OFF_TYPE_LOW, 32'h0);
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            e = (i == 0) ? 32'hffffffff : $urandom;
            p = $urandom;
            @(posedge clk_in);
            level <= r;
            wr32(`OFF_EN_LOW, e);
            wr32(`OFF_LVL_LOW, p);
            tick(4);
            wr32(`OFF_STAT_LOW, 32'hffffffff);
            tick(4);
            rd32(`OFF_STAT_LOW);
            check(rv32, lvl_exp(r, p, e));
        end
        // One low-half level source, then mask and clear it
        @(posedge clk_in);
        level <= 32'h0000_0001;
        wr32(`OFF_LVL_LOW, 32'hffffffff);
        wr32(`OFF_EN_LOW, 32'h0000_0001);
        wr32(`OFF_STAT_LOW, 32'hffffffff);
        tick(5);
        check({31'h0, irq_out}, 32'h1);
        wr(`OFF_MASK_LOW, 16'h0000);
        tick(3);
        check({31'h0, irq_out}, 32'h0);
        wr(`OFF_MASK_LOW, 16'hffff);
        wr32(`OFF_EN_LOW, 32'h0);
        wr32(`OFF_STAT_LOW, 32'hffffffff);
        tick(3);
        check({31'h0, irq_out}, 32'h0);
        rd32(`OFF_STAT_LOW);
        check(rv32, 32'h0);
        final_report();
    end
endmodule : testbench

// ### verilog/gpio_pin_interrupt_detect.sv
`timescale 1ns/1ps
`include "gpio_irq_defines.svh"

// Contract
// - Status reads one after event; write one clears
// - Set only when enabled and condition met
// - Upper status bits map pins 31..16
// - Enable one permits, zero blocks setting
// - Lower enable bits map pins 15..0
// - Upper enable bits map pins 31..16
// - Trigger bit one edge, zero level
// - Edge mode fires on both transitions
// - Level mode detects selected input level
// - Lower trigger bits map pins 15..0
// - Pin 15 is fixed carrier-detect input
// - Polarity one high active, zero low
// - Polarity ignored while edge mode selected
// - Lower status sticky write-one-clear for 15..0
module gpio_pin_interrupt_detect
    import gpio_irq_pkg::*;
#(
    parameter int PIN_COUNT = 32
) (
    input wire logic clk_in, // 25 MHz system clock
    input wire logic srst_in, // Synchronous reset, high
    input wire logic [31:0] pins_in, // Pin levels, bit 15 unused
    input wire logic carrier_detect_in, // Raw carrier-detect pin level
    input wire logic [31:0] addr_in, // Register byte address
    input wire logic [15:0] wdata_in, // Write data
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    output logic [15:0] rdata_out, // Read data, cycle after strobe
    output logic irq_out // Level interrupt request
);

    localparam int HALF = 16; // Bits per register half

    // Configuration and state, one bit per pin
    logic [31:0] allow; // Detection enables
    logic [31:0] kind; // 1 edge, 0 level
    logic [31:0] polarity; // 1 high active, 0 low active
    logic [31:0] mask; // Interrupt output mask, 1 passes
    logic [31:0] status; // Sticky event flags
    logic [31:0] raw; // Pin bank with carrier on bit 15
    logic [31:0] cur; // Synchronised sample
    logic [31:0] prev; // Sample one cycle older
    logic [31:0] hit; // Per-pin condition this cycle
    logic [31:0] clr; // Write-one-clear request
    logic [31:0] next_status; // Status for next edge
    logic [15:0] next_rdata; // Read mux result
    logic [31:0] edge_seen; // Enabled edge-mode pins that moved
    logic any_pending; // Some unmasked flag is set

    // The logic is built around two 16-bit halves
    if (PIN_COUNT != 2 * HALF) begin : bad_count
        $error("gpio_pin_interrupt_detect supports exactly 32 pins");
    end

    // carrier on pin 15
    // Pin 15 has no output driver; it always carries carrier detect
    assign raw = {pins_in[`HIGH_MSB:`HIGH_LSB], carrier_detect_in,
                  pins_in[`CARRIER_PIN-1:`LOW_LSB]};

    pin_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .async_in(raw),
        .sync_out(cur)
    );

    // previous sample
    // Edges are judged between two synced samples, never raw pins
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            prev <= '0;
        end else begin
            prev <= cur;
        end
    end

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        pin_detect u_det (
            .allow_in(allow[i]),
            .kind_in(trig_kind_t'(kind[i])),
            .polarity_in(polarity_t'(polarity[i])),
            .cur_in(cur[i]),
            .prev_in(prev[i]),
            .hit_out(hit[i])
        );
    end

    // lower enable
    // Enable registers, halves written independently
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            allow <= {`RST_CFG, `RST_CFG};
        end else if (wr_in) begin
            if (addr_in == `OFF_EN_LOW) begin
                allow[`LOW_MSB:`LOW_LSB] <= wdata_in;
            end
            if (addr_in == `OFF_EN_HIGH) begin
                allow[`HIGH_MSB:`HIGH_LSB] <= wdata_in;
            end
        end
    end

    // lower trigger type
    // Trigger type registers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            kind <= {`RST_CFG, `RST_CFG};
        end else if (wr_in) begin
            if (addr_in == `OFF_TYPE_LOW) begin
                kind[`LOW_MSB:`LOW_LSB] <= wdata_in;
            end
            if (addr_in == `OFF_TYPE_HIGH) begin
                kind[`HIGH_MSB:`HIGH_LSB] <= wdata_in;
            end
        end
    end

    // polarity registers
    // Stored in edge mode too, only the detector disregards them
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            polarity <= {`RST_CFG, `RST_CFG};
        end else if (wr_in) begin
            if (addr_in == `OFF_LVL_LOW) begin
                polarity[`LOW_MSB:`LOW_LSB] <= wdata_in;
            end
            if (addr_in == `OFF_LVL_HIGH) begin
                polarity[`HIGH_MSB:`HIGH_LSB] <= wdata_in;
            end
        end
    end

    // Output mask; resets open so every flag reaches the output
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mask <= {`RST_MASK, `RST_MASK};
        end else if (wr_in) begin
            if (addr_in == `OFF_MASK_LOW) begin
                mask[`LOW_MSB:`LOW_LSB] <= wdata_in;
            end
            if (addr_in == `OFF_MASK_HIGH) begin
                mask[`HIGH_MSB:`HIGH_LSB] <= wdata_in;
            end
        end
    end

    always_comb begin
        clr = '0;
        if (wr_in && addr_in == `OFF_STAT_LOW) begin
            clr[`LOW_MSB:`LOW_LSB] = wdata_in;
        end
        if (wr_in && addr_in == `OFF_STAT_HIGH) begin
            clr[`HIGH_MSB:`HIGH_LSB] = wdata_in;
        end
    end

    // gated sticky set
    // A new hit beats a clear in the same cycle so no event is lost;
    // level pins re-set every cycle while the level persists
    assign next_status = (status & ~clr) | hit;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status <= {`RST_STAT, `RST_STAT};
        end else begin
            status <= next_status;
        end
    end

    // Plain nets so the checks below can look back on single signals
    assign edge_seen = allow & kind & (cur ^ prev);
    assign any_pending = |(status & mask);

    // interrupt output
    // Registered so the pin never glitches on a read or write
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= any_pending;
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        case (addr_in)
            `OFF_STAT_LOW: next_rdata = status[`LOW_MSB:`LOW_LSB];
            `OFF_STAT_HIGH: next_rdata = status[`HIGH_MSB:`HIGH_LSB];
            `OFF_EN_LOW: next_rdata = allow[`LOW_MSB:`LOW_LSB];
            `OFF_EN_HIGH: next_rdata = allow[`HIGH_MSB:`HIGH_LSB];
            `OFF_TYPE_LOW: next_rdata = kind[`LOW_MSB:`LOW_LSB];
            `OFF_TYPE_HIGH: next_rdata = kind[`HIGH_MSB:`HIGH_LSB];
            `OFF_LVL_LOW: next_rdata = polarity[`LOW_MSB:`LOW_LSB];
            `OFF_LVL_HIGH: next_rdata = polarity[`HIGH_MSB:`HIGH_LSB];
            `OFF_MASK_LOW: next_rdata = mask[`LOW_MSB:`LOW_LSB];
            `OFF_MASK_HIGH: next_rdata = mask[`HIGH_MSB:`HIGH_LSB];
            default: next_rdata = `RST_RDATA;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= `RST_RDATA;
        end else if (rd_in) begin
            rdata_out <= next_rdata;
        end else begin
            rdata_out <= `RST_RDATA;
        end
    end

    // Checks share one clock and the reset
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (srst_in);

    // Written ones clear unless a hit arrives alongside
    chk_w1c_clear: assert property (
        (wr_in && addr_in == `OFF_STAT_LOW) |=>
            ((status[15:0] & $past(wdata_in) & ~$past(hit[15:0])) == 16'h0000))
        else $error("status bit survived a write-one clear");

    // A zero written never clears
    chk_w0_keeps: assert property (
        (wr_in && addr_in == `OFF_STAT_HIGH && wdata_in == 16'h0000) |=>
            ((status[31:16] & $past(status[31:16])) == $past(status[31:16])))
        else $error("status bit lost on a zero write");

    // No flag rises without a qualified hit
    chk_no_spurious: assert property (
        ((status & ~$past(status) & ~$past(hit)) == 32'h0000_0000))
        else $error("status set without a hit");

    // Disabled pins never set
    chk_disabled_pin: assert property (
        ((status & ~$past(status) & ~$past(allow)) == 32'h0000_0000))
        else $error("status set on a prohibited pin");

    // Both edge directions set the flag next cycle
    chk_edge_both: assert property (
        (edge_seen != 32'h0000_0000) |=>
            ((status & $past(edge_seen)) == $past(edge_seen)))
        else $error("edge not captured");

    // Level mode follows the programmed polarity
    chk_level_sense: assert property (
        (hit & ~kind) == (allow & ~kind & ~(cur ^ polarity)))
        else $error("level detect disagrees with polarity");

    // Polarity has no say in edge mode
    chk_edge_no_pol: assert property (
        (hit & kind) == (allow & kind & (cur ^ prev)))
        else $error("polarity leaked into edge mode");

    // Carrier input reaches pin 15 after two flops
    chk_carrier_sync: assert property (
        ##2 (cur[15] == $past(carrier_detect_in, 2)))
        else $error("carrier detect not on pin 15");

    // Upper status read returns pins 31..16 next cycle
    chk_read_high: assert property (
        (rd_in && addr_in == `OFF_STAT_HIGH) |=>
            (rdata_out == $past(status[31:16])))
        else $error("upper status read mismatch");

    // Lower status read returns pins 15..0 next cycle
    chk_read_low: assert property (
        (rd_in && addr_in == `OFF_STAT_LOW) |=> (rdata_out == $past(status[15:0])))
        else $error("lower status read mismatch");

    // Upper enable writes land on pins 31..16
    chk_enable_map: assert property (
        (wr_in && addr_in == `OFF_EN_HIGH) |=> (allow[31:16] == $past(wdata_in)))
        else $error("upper enable not stored");

    // Interrupt follows masked status one cycle later
    chk_irq_level: assert property (
        ##1 (irq_out == $past(any_pending)))
        else $error("interrupt output wrong");

    // Main scenarios
    cov_edge_set: cover property ((allow & kind & (cur ^ prev)) != 32'h0 ##1 irq_out);
    cov_level_set: cover property ((hit & ~kind) != 32'h0);
    cov_clear_race: cover property (wr_in && addr_in == `OFF_STAT_LOW && (clr & hit) != 32'h0);
    cov_irq_fall: cover property (irq_out ##1 !irq_out);
    cov_carrier_edge: cover property (edge_seen[15]);

endmodule : gpio_pin_interrupt_detect

// ### verilog/pin_detect.sv
`timescale 1ns/1ps

module pin_detect
    import gpio_irq_pkg::*;
(
    input wire logic allow_in, // Detection permitted
    input wire trig_kind_t kind_in, // Edge or level
    input wire polarity_t polarity_in, // Active level in level mode
    input wire logic cur_in, // Current synced sample
    input wire logic prev_in, // Previous synced sample
    output logic hit_out // Condition met this cycle
);

    // Polarity is ignored in edge mode; either transition counts
    always_comb begin
        if (!allow_in) begin
            hit_out = 1'b0;
        end else if (kind_in == trig_edge) begin
            hit_out = cur_in ^ prev_in;
        end else begin
            hit_out = (cur_in == (polarity_in == pol_high));
        end
    end

endmodule : pin_detect

// ### verilog/pin_sync.sv
`timescale 1ns/1ps
`include "gpio_irq_defines.svh"

module pin_sync #(
    parameter int WIDTH = 32
) (
    input wire logic clk_in, // System clock
    input wire logic srst_in, // Synchronous reset, high
    input wire logic [WIDTH-1:0] async_in, // Raw pin levels
    output logic [WIDTH-1:0] sync_out // Levels safe to use
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta;

    // Refuse a zero-width bank
    if (WIDTH < 1) begin : bad_width
        $error("pin_sync needs at least one bit");
    end

    // Two flops ahead of any logic to tame metastability
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule : pin_sync
